/* File: common/spm_cfg.svh */
`ifndef SPM_CFG_SVH
`define SPM_CFG_SVH

`define CSR_DATA_ADDR 8'h57
`define IO_SPACE_OFS 8'h20
`define CSR_RESET 8'h00

`define BIT_IE 7
`define BIT_SIG_READ 5
`define BIT_SECT_READ_EN 4
`define BIT_STORE_EN 0

`define CMD_FILL 5'h01
`define CMD_ERASE 5'h03
`define CMD_WRITE 5'h05
`define CMD_LOCK 5'h09
`define CMD_RWW 5'h11

`define STORE_WIN 3'h4
`define LOAD_OK_MIN 3'h2
`define WIN_LAST 3'h1

`define Z_PAGE_HI 12
`define Z_PAGE_LO 6
`define Z_WORD_HI 5
`define Z_WORD_LO 1
`define Z_SEL_LO 0
`define Z_SEL_HI 1

`define SEL_FUSE_LOW 2'h0
`define SEL_LOCK 2'h1
`define SEL_FUSE_EXT 2'h2
`define SEL_FUSE_HIGH 2'h3

`define CLK_KHZ 40000
// microseconds keep the product inside 32-bit integer arithmetic
`define OP_MIN_US 3200
`define OP_MAX_US 3400
`define OP_MIN_CYC ((`OP_MIN_US * `CLK_KHZ + 999) / 1000)
`define OP_MAX_CYC ((`OP_MAX_US * `CLK_KHZ) / 1000)

`define PAGE_WORDS 32
`define WORD_BITS 16

`endif

/* File: common/spm_pkg.sv */
package spm_pkg;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_FILL = 3'b001,
    M_ERASE = 3'b010,
    M_WRITE = 3'b011,
    M_LOCK = 3'b100,
    M_SIG = 3'b101,
    M_RWW = 3'b110
  } mode_t;

  typedef struct packed {
    logic erase;
    logic write;
    logic lock_wr;
    logic [7:0] lock_data;
    logic [6:0] page;
  } flash_cmd_t;

  typedef struct packed {
    logic ie;
    logic [5:0] cmd;
    mode_t mode;
    logic [2:0] win;
    logic busy;
    logic halt;
    logic irq;
    logic [7:0] rdata;
    logic lpm_valid;
    logic [7:0] lpm_data;
    flash_cmd_t fl;
  } ctl_st_t;

endpackage

/* File: design/op_timer.sv */
`timescale 1ns/1ps
`include "spm_cfg.svh"

module op_timer #(
  parameter int CYCLES = `OP_MIN_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic done_o
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } tmr_st_t;

  tmr_st_t st_r;
  tmr_st_t st_nxt;

  // done fires on the last counted cycle, so busy spans exactly CYCLES
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start_i) begin
      st_nxt.cnt = CW'(CYCLES);
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CW'(1);
      st_nxt.done = (st_r.cnt == CW'(2));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign done_o = st_r.done;
endmodule

/* File: design/page_buffer.sv */
`timescale 1ns/1ps
`include "spm_cfg.svh"

module page_buffer #(
  parameter int WORDS = `PAGE_WORDS,
  parameter int WIDTH = `WORD_BITS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clr_i,
  input wire logic we_i,
  input wire logic [$clog2(WORDS)-1:0] widx_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [$clog2(WORDS)-1:0] ridx_i,
  output logic [WIDTH-1:0] rdata_o
);
  typedef struct packed {
    logic [WORDS-1:0] valid;
    logic [WIDTH-1:0] rdata;
  } buf_st_t;

  logic [WIDTH-1:0] mem [WORDS];
  buf_st_t st_r;
  buf_st_t st_nxt;

  // clearing only drops the valid bits; the array itself needs no reset
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = st_r.valid[ridx_i] ? mem[ridx_i] : {WIDTH{1'b1}};
    if (clr_i) begin
      st_nxt.valid = '0;
    end else if (we_i) begin
      st_nxt.valid[widx_i] = 1'b1;
    end
  end

  // a word can be loaded once per clear; later loads are dropped
  always_ff @(posedge clk_i) begin
    if (we_i && !clr_i && !st_r.valid[widx_i]) begin
      mem[widx_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_o = st_r.rdata;
endmodule

/* File: design/self_program_flash_control.sv */
// Function
// - each erase, page write or lock write lasts 3.2 to 3.4 ms
// - ready interrupt asserted while enable, global flag set, store enable clear
// - ready interrupt suppressed during eeprom write or store operation
// - bit 6 section busy flag always reads zero
// - signature command lets next load return signature byte, ignores stores
// - writing section read enable bit while filling clears page buffer
// - lock command lets load within three cycles return lock or fuse bits
// - page write command writes buffer to page from high Z bits
// - page write bit clears on completion or four idle cycles
// - page erase command erases page from high Z bits on store
// - page erase bit clears on completion or four idle cycles
// - cpu halted for whole page write and page erase
// - store enable alone arms buffer load of R1:R0 at Z word
// - store enable clears after store or four cycles without store
// - store enable stays one until erase or write completes
// - only five listed low-bit patterns act, others ignored
// - control register at data address 0x57, io address 0x37
// - page from Z bits 12:6, buffer word from Z bits 5:1
// - buffer cleared after page write, section read enable write, reset
// - eeprom write blocks programming and fuse or lock reads
// - programmed fuse and lock bits read zero, unprogrammed one
`timescale 1ns/1ps
`include "spm_cfg.svh"

module self_program_flash_control #(
  parameter int OP_CYCLES = `OP_MIN_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] IO_ADDR_I,
  input wire logic IO_SPACE_I,
  input wire logic IO_WE_I,
  input wire logic IO_RE_I,
  input wire logic [7:0] IO_WDATA_I,
  output logic [7:0] IO_RDATA_O,
  input wire logic SPM_I,
  input wire logic LPM_I,
  input wire logic [15:0] Z_I,
  input wire logic [15:0] R_WORD_I,
  input wire logic GIE_I,
  input wire logic EE_BUSY_I,
  input wire logic [7:0] FUSE_LOW_PRG_I,
  input wire logic [7:0] FUSE_HIGH_PRG_I,
  input wire logic [7:0] FUSE_EXT_PRG_I,
  input wire logic [7:0] LOCK_PRG_I,
  input wire logic [7:0] SIG_BYTE_I,
  output logic LPM_VALID_O,
  output logic [7:0] LPM_DATA_O,
  output logic CPU_HALT_O,
  output logic READY_IRQ_O,
  output spm_pkg::flash_cmd_t FLASH_CMD_O,
  input wire logic [4:0] BUF_RD_IDX_I,
  output logic [15:0] BUF_RD_DATA_O
);
  import spm_pkg::*;

  ctl_st_t st_r;
  ctl_st_t st_nxt;
  logic [7:0] addr_eff;
  logic csr_wr;
  logic csr_rd;
  logic [7:0] csr_val;
  logic buf_clr;
  logic buf_we;
  logic tmr_start;
  logic op_done;

  function automatic mode_t decode_cmd(input logic [7:0] wd);
    mode_t m;
    case (wd[4:0])
      `CMD_FILL: m = wd[`BIT_SIG_READ] ? M_SIG : M_FILL;
      `CMD_ERASE: m = M_ERASE;
      `CMD_WRITE: m = M_WRITE;
      `CMD_LOCK: m = M_LOCK;
      `CMD_RWW: m = M_RWW;
      default: m = M_IDLE;
    endcase
    if (wd[`BIT_SIG_READ] && wd[4:0] != `CMD_FILL) begin
      m = M_IDLE;
    end
    return m;
  endfunction

  function automatic logic [7:0] fuse_lock_byte(input logic [1:0] sel);
    logic [7:0] v;
    case (sel)
      `SEL_FUSE_LOW: v = ~FUSE_LOW_PRG_I;
      `SEL_LOCK: v = ~LOCK_PRG_I;
      `SEL_FUSE_EXT: v = ~FUSE_EXT_PRG_I;
      `SEL_FUSE_HIGH: v = ~FUSE_HIGH_PRG_I;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // register decode
  // io-space addressing
  assign addr_eff = IO_SPACE_I ? IO_ADDR_I + `IO_SPACE_OFS : IO_ADDR_I;
  assign csr_wr = IO_WE_I && (addr_eff == `CSR_DATA_ADDR);
  assign csr_rd = IO_RE_I && (addr_eff == `CSR_DATA_ADDR);
  assign csr_val = {st_r.ie, 1'b0, st_r.cmd};

  ////////////////////////////////////////////////////////////////////
  // command sequencing
  always_comb begin
    st_nxt = st_r;
    st_nxt.lpm_valid = 1'b0;
    buf_clr = 1'b0;
    buf_we = 1'b0;
    tmr_start = 1'b0;
    if (csr_rd) begin
      st_nxt.rdata = csr_val;
    end
    if (csr_wr) begin
      st_nxt.ie = IO_WDATA_I[`BIT_IE];
    end
    if (st_r.busy) begin
      if (op_done) begin
        buf_clr = (st_r.mode == M_WRITE);
        st_nxt.busy = 1'b0;
        st_nxt.halt = 1'b0;
        st_nxt.cmd = '0;
        st_nxt.mode = M_IDLE;
        st_nxt.fl.erase = 1'b0;
        st_nxt.fl.write = 1'b0;
        st_nxt.fl.lock_wr = 1'b0;
      end
    end else begin
      if (st_r.win != '0) begin
        st_nxt.win = st_r.win - 3'h1;
        if (st_r.win == `WIN_LAST) begin
          st_nxt.cmd = '0;
          st_nxt.mode = M_IDLE;
        end
      end
      if (SPM_I && st_r.win != '0 && !EE_BUSY_I) begin
        st_nxt.win = '0;
        st_nxt.cmd = '0;
        st_nxt.mode = M_IDLE;
        case (st_r.mode)
          M_FILL: begin
            buf_we = 1'b1;
          end
          M_ERASE, M_WRITE: begin
            tmr_start = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.halt = 1'b1;
            st_nxt.cmd = st_r.cmd;
            st_nxt.mode = st_r.mode;
            st_nxt.fl.erase = (st_r.mode == M_ERASE);
            st_nxt.fl.write = (st_r.mode == M_WRITE);
            st_nxt.fl.page = Z_I[`Z_PAGE_HI:`Z_PAGE_LO];
          end
          M_LOCK: begin
            tmr_start = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.cmd = st_r.cmd;
            st_nxt.mode = st_r.mode;
            st_nxt.fl.lock_wr = 1'b1;
            st_nxt.fl.lock_data = R_WORD_I[7:0];
          end
          M_SIG: begin
            st_nxt.win = st_r.win - 3'h1;
            st_nxt.cmd = (st_r.win == `WIN_LAST) ? 6'h00 : st_r.cmd;
            st_nxt.mode = (st_r.win == `WIN_LAST) ? M_IDLE : st_r.mode;
          end
          default: begin
          end
        endcase
      end
      if (LPM_I && st_r.win >= `LOAD_OK_MIN && !EE_BUSY_I
          && (st_r.mode == M_LOCK || st_r.mode == M_SIG)) begin
        st_nxt.lpm_valid = 1'b1;
        st_nxt.lpm_data = (st_r.mode == M_SIG) ? SIG_BYTE_I
                        : fuse_lock_byte(Z_I[`Z_SEL_HI:`Z_SEL_LO]);
        st_nxt.win = '0;
        st_nxt.cmd = '0;
        st_nxt.mode = M_IDLE;
      end
      if (csr_wr && !EE_BUSY_I && decode_cmd(IO_WDATA_I) != M_IDLE) begin
        st_nxt.cmd = IO_WDATA_I[5:0];
        st_nxt.mode = decode_cmd(IO_WDATA_I);
        st_nxt.win = `STORE_WIN;
      end
    end
    if (csr_wr && IO_WDATA_I[`BIT_SECT_READ_EN] && !EE_BUSY_I) begin
      buf_clr = 1'b1;
    end
    st_nxt.irq = st_nxt.ie && GIE_I && !st_nxt.cmd[`BIT_STORE_EN]
                 && !EE_BUSY_I && !st_nxt.busy;
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // leaves
  // operation timing
  op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .start_i(tmr_start),
    .done_o(op_done)
  );

  page_buffer #(
    .WORDS(`PAGE_WORDS),
    .WIDTH(`WORD_BITS)
  ) u_buf (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clr_i(buf_clr),
    .we_i(buf_we),
    .widx_i(Z_I[`Z_WORD_HI:`Z_WORD_LO]),
    .wdata_i(R_WORD_I),
    .ridx_i(BUF_RD_IDX_I),
    .rdata_o(BUF_RD_DATA_O)
  );

  assign IO_RDATA_O = st_r.rdata;
  assign LPM_VALID_O = st_r.lpm_valid;
  assign LPM_DATA_O = st_r.lpm_data;
  assign CPU_HALT_O = st_r.halt;
  assign READY_IRQ_O = st_r.irq;
  assign FLASH_CMD_O = st_r.fl;

  ////////////////////////////////////////////////////////////////////
  // checks
  logic [17:0] busy_cnt;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_cnt <= 18'h00000;
    end else begin
      busy_cnt <= st_r.busy ? busy_cnt + 18'h00001 : 18'h00000;
    end
  end

  sequence s_arm(logic [4:0] pat);
    csr_wr && IO_WDATA_I[5:0] == {1'b0, pat} && !EE_BUSY_I && !st_r.busy;
  endsequence

  sequence s_quiet4;
    (!SPM_I && !LPM_I && !csr_wr)[*4];
  endsequence
  property p_busy_flag_zero;
    @(posedge CLK_I) disable iff (!RST_N_I) csr_rd |=> IO_RDATA_O[6] == 1'b0;
  endproperty
  a_busy_flag_zero: assert property (p_busy_flag_zero)
    else $error("section busy flag read as one");
  property p_irq_gate;
    @(posedge CLK_I) disable iff (!RST_N_I)
      READY_IRQ_O |-> st_r.ie && !st_r.cmd[`BIT_STORE_EN] && !st_r.busy;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("ready interrupt without enable or with store enable set");
  property p_irq_ee;
    @(posedge CLK_I) disable iff (!RST_N_I) EE_BUSY_I |=> !READY_IRQ_O;
  endproperty
  a_irq_ee: assert property (p_irq_ee)
    else $error("ready interrupt during eeprom write");
  property p_fill_expire;
    @(posedge CLK_I) disable iff (!RST_N_I)
      s_arm(`CMD_FILL) ##1 s_quiet4 |=> st_r.cmd == 6'h00;
  endproperty
  a_fill_expire: assert property (p_fill_expire)
    else $error("store enable not cleared after four idle cycles");
  property p_erase_halt;
    @(posedge CLK_I) disable iff (!RST_N_I)
      s_arm(`CMD_ERASE) ##1 (SPM_I && !EE_BUSY_I)
      |=> CPU_HALT_O && FLASH_CMD_O.erase;
  endproperty
  a_erase_halt: assert property (p_erase_halt)
    else $error("page erase did not halt the cpu");
  property p_hold_enable;
    @(posedge CLK_I) disable iff (!RST_N_I) st_r.busy |-> st_r.cmd[`BIT_STORE_EN];
  endproperty
  a_hold_enable: assert property (p_hold_enable)
    else $error("store enable dropped during operation");
  property p_op_length;
    @(posedge CLK_I) disable iff (!RST_N_I) $fell(st_r.busy) |-> busy_cnt == 18'(OP_CYCLES);
  endproperty
  a_op_length: assert property (p_op_length)
    else $error("flash operation length wrong");
  property p_io_addr;
    @(posedge CLK_I) disable iff (!RST_N_I)
      IO_RE_I && IO_SPACE_I && IO_ADDR_I == 8'(`CSR_DATA_ADDR - `IO_SPACE_OFS)
      |=> IO_RDATA_O == {$past(st_r.ie), 1'b0, $past(st_r.cmd)};
  endproperty
  a_io_addr: assert property (p_io_addr)
    else $error("control register not at io address");
  property p_sig_no_store;
    @(posedge CLK_I) disable iff (!RST_N_I)
      csr_wr && IO_WDATA_I[5:0] == 6'h21 && !EE_BUSY_I && !st_r.busy
      ##1 SPM_I |=> !st_r.busy && !CPU_HALT_O;
  endproperty
  a_sig_no_store: assert property (p_sig_no_store)
    else $error("store acted after signature command");
  property p_invalid_cmd;
    @(posedge CLK_I) disable iff (!RST_N_I)
      csr_wr && decode_cmd(IO_WDATA_I) == M_IDLE && st_r.cmd == 6'h00
      && !st_r.busy |=> st_r.cmd == 6'h00;
  endproperty
  a_invalid_cmd: assert property (p_invalid_cmd)
    else $error("invalid command pattern took effect");
endmodule

/* File: sim/cpu_core_model.sv */
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic clk_i,
  input wire logic ee_i,
  input wire logic [7:0] rd_i,
  output logic [7:0] adr_o,
  output logic sp_o,
  output logic we_o,
  output logic re_o,
  output logic [7:0] wd_o,
  output logic spm_o,
  output logic lpm_o,
  output logic [15:0] z_o,
  output logic [15:0] r_o
);
  logic polite;
  logic [7:0] st;
  initial begin
    {adr_o, sp_o, we_o, re_o, wd_o, spm_o, lpm_o, z_o, r_o} = '0;
    polite = 1'b1;
  end
  ////////////////////////////////////////
  // released data lines show the inverse, not the last value
  task automatic wr(input logic [7:0] a, input logic s, input logic [7:0] d);
    @(negedge clk_i);
    adr_o = a;
    sp_o = s;
    wd_o = d;
    we_o = 1'b1;
    @(negedge clk_i);
    we_o = 1'b0;
    wd_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic s, output logic [7:0] d);
    @(negedge clk_i);
    adr_o = a;
    sp_o = s;
    re_o = 1'b1;
    @(negedge clk_i);
    re_o = 1'b0;
    d = rd_i;
  endtask
  task automatic idle();
    st = 8'h01;
    while (polite && (st[0] !== 1'b0 || ee_i)) begin
      rd(8'h57, 1'b0, st);
    end
  endtask
  // gap 0 puts the instruction one cycle after the write edge
  task automatic cmd(input logic [7:0] c, input logic [15:0] z, input logic [15:0] r,
    input int gap, input logic ld);
    idle();
    wr(8'h57, 1'b0, c);
    repeat (gap) @(negedge clk_i);
    z_o = z;
    r_o = r;
    spm_o = ~ld;
    lpm_o = ld;
    @(negedge clk_i);
    {spm_o, lpm_o} = 2'b00;
    z_o = ~z;
    r_o = ~r;
  endtask
endmodule

/* File: sim/self_program_flash_control_tb_top.sv */
`timescale 1ns/1ps
module self_program_flash_control_tb_top;
  import spm_pkg::*;
  localparam int OPC = 20;
  localparam logic [7:0] OPS [4] = '{8'h03, 8'h05, 8'h09, 8'h03};
  localparam logic [7:0] BAD [6] = '{8'h07, 8'h13, 8'h0F, 8'h1F, 8'h02, 8'h21};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic gie = 1'b0;
  logic ee = 1'b0;
  logic [4:0] bidx = 5'h00;
  logic [7:0] sig;
  logic [7:0] prg [4];
  logic [7:0] adr, wd, rdat, lpm_d;
  logic sp, we, re, spm, lpm, lpm_v, halt, irq;
  logic [15:0] z_w, r_w, bdata;
  flash_cmd_t fc;
  logic [6:0] pg;
  logic [15:0] img [32];
  logic [31:0] seed = 32'h1F;
  int cnt [4] = '{default: 0};
  int err_total = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  cpu_core_model u_cpu (.clk_i(clk), .ee_i(ee), .rd_i(rdat), .adr_o(adr), .sp_o(sp),
    .we_o(we), .re_o(re), .wd_o(wd), .spm_o(spm), .lpm_o(lpm), .z_o(z_w), .r_o(r_w));
  self_program_flash_control #(.OP_CYCLES(OPC)) dut (.CLK_I(clk), .RST_N_I(rst_n),
    .IO_ADDR_I(adr), .IO_SPACE_I(sp), .IO_WE_I(we), .IO_RE_I(re), .IO_WDATA_I(wd),
    .IO_RDATA_O(rdat), .SPM_I(spm), .LPM_I(lpm), .Z_I(z_w), .R_WORD_I(r_w), .GIE_I(gie),
    .EE_BUSY_I(ee), .FUSE_LOW_PRG_I(prg[0]), .FUSE_HIGH_PRG_I(prg[3]),
    .FUSE_EXT_PRG_I(prg[2]), .LOCK_PRG_I(prg[1]), .SIG_BYTE_I(sig), .LPM_VALID_O(lpm_v),
    .LPM_DATA_O(lpm_d), .CPU_HALT_O(halt), .READY_IRQ_O(irq), .FLASH_CMD_O(fc),
    .BUF_RD_IDX_I(bidx), .BUF_RD_DATA_O(bdata));
  // cycle counts of the timed levels
  always @(negedge clk) begin
    cnt[0] += int'(halt === 1'b1);
    cnt[1] += int'(fc.erase === 1'b1);
    cnt[2] += int'(fc.write === 1'b1);
    cnt[3] += int'(fc.lock_wr === 1'b1);
    if (halt === 1'b1) pg = fc.page;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] fuse_exp(input logic [1:0] s);
    return ~prg[s];
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_buf(input string what);
    for (int i = 0; i < 32; i++) begin
      @(negedge clk);
      bidx = 5'(i);
      @(negedge clk);
      chk(what, img[i], bdata);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // run needs about 600 cycles, so this leaves ample margin
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    logic [7:0] v;
    logic [15:0] z;
    logic [15:0] w;
    int g;
    int c0 [4];
    sig = 8'(rnd());
    for (int i = 0; i < 4; i++) prg[i] = 8'(rnd());
    foreach (img[i]) img[i] = 16'hFFFF;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    u_cpu.rd(8'h57, 1'b0, v);
    chk("csr", 16'h0000, {8'h00, v});
    u_cpu.wr(8'h37, 1'b1, 8'hC0);
    u_cpu.wr(8'h58, 1'b0, 8'h00);
    u_cpu.rd(8'h57, 1'b0, v);
    chk("csr", 16'h0080, {8'h00, v});
    u_cpu.rd(8'h37, 1'b1, v);
    chk("csr_io", 16'h0080, {8'h00, v});
    gie = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq", 16'h0001, 16'(irq));
    ee = 1'b1;
    repeat (3) @(negedge clk);
    chk("irq", 16'h0000, 16'(irq));
    ee = 1'b0;
    gie = 1'b0;
    repeat (3) @(negedge clk);
    chk("irq", 16'h0000, 16'(irq));
    u_cpu.wr(8'h57, 1'b0, 8'h00);
    g = cnt[0];
    foreach (BAD[i]) u_cpu.cmd(BAD[i], 16'h0000, 16'(rnd()), 0, 1'b0);
    u_cpu.idle();
    chk("halt", 16'(g), 16'(cnt[0]));
    check_buf("bad");
    for (int i = 0; i < 12; i++) begin
      z = 16'(rnd());
      w = 16'(rnd());
      g = (i == 5) ? 4 : int'(rnd() % 4);
      u_cpu.cmd(8'h01, z, w, g, 1'b0);
      if (g < 4 && img[z[5:1]] === 16'hFFFF) img[z[5:1]] = w;
    end
    check_buf("fill");
    u_cpu.rd(8'h57, 1'b0, v);
    chk("csr", 16'h0000, {8'h00, v});
    u_cpu.cmd(8'h11, 16'h0000, 16'h0000, 0, 1'b0);
    foreach (img[i]) img[i] = 16'hFFFF;
    check_buf("rww");
    u_cpu.cmd(8'h01, 16'h0002, 16'h1234, 0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      foreach (c0[j]) c0[j] = cnt[j];
      z = 16'(rnd());
      w = 16'(rnd());
      g = (i == 3) ? 4 : (i == 0) ? 0 : int'(rnd() % 4);
      u_cpu.cmd(OPS[i], z, w, g, 1'b0);
      u_cpu.idle();
      repeat (2) @(negedge clk);
      chk("halt", (i < 2) ? 16'(OPC) : 16'h0, 16'(cnt[0] - c0[0]));
      chk("len", (i < 3) ? 16'(OPC) : 16'h0, 16'(cnt[i % 3 + 1] - c0[i % 3 + 1]));
      if (i < 2) chk("page", 16'(z[12:6]), 16'(pg));
      if (i == 2) chk("lockd", {8'h00, w[7:0]}, {8'h00, fc.lock_data});
      u_cpu.rd(8'h57, 1'b0, v);
      chk("csr", 16'h0000, {8'h00, v});
    end
    check_buf("wr");
    for (int s = 0; s < 5; s++) begin
      z = (s < 4) ? 16'(s) : 16'(rnd());
      u_cpu.cmd((s < 4) ? 8'h09 : 8'h21, z, 16'h0000, int'(rnd() % 3), 1'b1);
      chk("lpmv", 16'h0001, 16'(lpm_v));
      chk("lpm", (s < 4) ? 16'(fuse_exp(2'(s))) : 16'(sig), 16'(lpm_d));
    end
    ee = 1'b1;
    u_cpu.polite = 1'b0;
    u_cpu.cmd(8'h01, 16'h0006, 16'h5A5A, 0, 1'b0);
    u_cpu.cmd(8'h09, 16'h0001, 16'h0000, 0, 1'b1);
    chk("lpmv", 16'h0000, 16'(lpm_v));
    ee = 1'b0;
    u_cpu.polite = 1'b1;
    check_buf("ee");
    end_of_test();
  end
endmodule
